// *** verilog/sphp_power_sequencer.sv ***
// Speaker and headphone driver power control, pop-removal timing and status registers

// Overview of operation
// - Bit 7 powers left speaker driver
// - Bit 6 powers right speaker driver
// - Bit 0 reads live short-circuit status
// - Short status meaningful only while powered
// - Bit 7 clear: DAC down with amplifiers
// - Bit 7 set: DAC down after amplifiers
// - Power-on time code, reset 0111
// - Ramp step time code, reset 11
// - Durations counted in oscillator cycles
// - Bit 0 clear: weak divider common mode
// - Short clears speaker bits unless held
module sphp_power_sequencer #(
    parameter longint OSC_KHZ = sphp_pkg::OSC_NOMINAL_KHZ,
    parameter int RAMP_STEPS = 8,
    parameter int LEVEL_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Internal oscillator tick, one pulse per oscillator cycle
    input wire logic osc_tick,
    // Error control and power-down sequence trigger
    input wire logic short_keep_speaker,
    input wire logic soft_power_down,
    // Analog status
    input wire logic class_d_short,
    input wire logic amplifiers_off,
    // Headphone and DAC requests
    input wire logic headphone_amplifier_request,
    input wire logic dac_request,
    // Speaker driver controls
    output logic left_speaker_output_enable,
    output logic right_speaker_output_enable,
    // Headphone driver controls
    output logic headphone_amplifier_enable,
    output logic [LEVEL_W-1:0] headphone_amplifier_level,
    output logic headphone_amplifier_ready,
    // DAC and common-mode controls
    output logic dac_enable,
    output logic common_mode_weak_drive
);

    localparam int TW = sphp_pkg::TIMER_W;

    if (RAMP_STEPS < 1 || RAMP_STEPS >= (1 << LEVEL_W)) begin : g_bad_steps
        $error("RAMP_STEPS must be at least 1 and fit in LEVEL_W bits");
    end
    if (OSC_KHZ < 1) begin : g_bad_osc
        $error("OSC_KHZ must be positive");
    end
    // The longest power-on wait must fit the shared timer
    if ((sphp_pkg::PON_TIME_NS[sphp_pkg::PON_LAST_CODE] * OSC_KHZ) / sphp_pkg::NS_PER_MS_KHZ
            >= (longint'(1) << TW)) begin : g_bad_timer
        $error("OSC_KHZ too high for the power-on timer width");
    end

    // Register offset match, shared by the write and read decoders
    function automatic logic offset_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction

    // Oscillator cycles for a time in ns, rounded down but kept at least one tick for a nonzero time
    function automatic logic [TW-1:0] osc_cycles(input longint time_ns);
        longint cycles;
        cycles = (time_ns * OSC_KHZ) / sphp_pkg::NS_PER_MS_KHZ;
        if (time_ns != 0 && cycles < 1) begin
            cycles = 1;
        end
        return TW'(cycles);
    endfunction

    // Reserved codes above the last are served as the longest time
    function automatic logic [TW-1:0] power_on_cycles(input logic [3:0] code);
        logic [3:0] index;
        index = (code > sphp_pkg::PON_LAST_CODE) ? sphp_pkg::PON_LAST_CODE : code;
        return osc_cycles(sphp_pkg::PON_TIME_NS[index]);
    endfunction

    // Register state
    logic left_speaker_q;
    logic left_speaker_d;
    logic right_speaker_q;
    logic right_speaker_d;
    logic [4:0] speaker_reserved_q;
    logic [4:0] speaker_reserved_d;
    logic short_seen_q;
    logic dac_delay_q;
    logic dac_delay_d;
    logic [3:0] power_on_code_q;
    logic [3:0] power_on_code_d;
    logic [1:0] step_code_q;
    logic [1:0] step_code_d;
    logic cm_select_q;
    logic cm_select_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;

    // Sequencing state
    sphp_pkg::sphp_seq_t seq_q;
    sphp_pkg::sphp_seq_t seq_d;
    logic [LEVEL_W-1:0] level_q;
    logic [LEVEL_W-1:0] level_d;
    logic power_down_q;
    logic power_down_d;

    // Decode
    logic write_speaker;
    logic write_headphone;
    logic short_clears;
    logic speaker_image_sel;
    logic headphone_image_sel;
    logic [7:0] speaker_image;
    logic [7:0] headphone_image;

    assign write_speaker = reg_write && speaker_image_sel;
    assign write_headphone = reg_write && headphone_image_sel;
    // Protection outranks a same-cycle software power-up so a short cannot be re-armed
    assign short_clears = class_d_short && !short_keep_speaker;

    assign left_speaker_d = short_clears ? 1'b0 :
        (write_speaker ? reg_wdata[sphp_pkg::LEFT_SPEAKER_BIT] : left_speaker_q);
    assign right_speaker_d = short_clears ? 1'b0 :
        (write_speaker ? reg_wdata[sphp_pkg::RIGHT_SPEAKER_BIT] : right_speaker_q);
    // Reserved field is stored as written; software keeps it at its reset pattern
    assign speaker_reserved_d = write_speaker ?
        reg_wdata[sphp_pkg::SPK_RSVD_MSB:sphp_pkg::SPK_RSVD_LSB] : speaker_reserved_q;

    assign dac_delay_d = write_headphone ? reg_wdata[sphp_pkg::DAC_DELAY_BIT] : dac_delay_q;
    // Reserved power-on codes are stored but never lengthen past the last time
    assign power_on_code_d = write_headphone ?
        reg_wdata[sphp_pkg::PON_MSB:sphp_pkg::PON_LSB] : power_on_code_q;
    assign step_code_d = write_headphone ?
        reg_wdata[sphp_pkg::STEP_MSB:sphp_pkg::STEP_LSB] : step_code_q;
    assign cm_select_d = write_headphone ? reg_wdata[sphp_pkg::CM_SEL_BIT] : cm_select_q;

    assign speaker_image = {left_speaker_q, right_speaker_q, speaker_reserved_q, short_seen_q};
    assign headphone_image = {dac_delay_q, power_on_code_q, step_code_q, cm_select_q};
    assign speaker_image_sel = offset_hit(reg_addr, sphp_pkg::SPEAKER_AMP_OFFSET);
    assign headphone_image_sel = offset_hit(reg_addr, sphp_pkg::HEADPHONE_POP_OFFSET);
    // Unmapped offsets read as zero
    assign rdata_d = !reg_read ? rdata_q :
                     speaker_image_sel ? speaker_image :
                     headphone_image_sel ? headphone_image : 8'h00;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            left_speaker_q <= 1'b0;
            right_speaker_q <= 1'b0;
            speaker_reserved_q <= sphp_pkg::SPK_RSVD_RESET;
            dac_delay_q <= 1'b0;
            power_on_code_q <= sphp_pkg::PON_RESET;
            step_code_q <= sphp_pkg::STEP_RESET;
            cm_select_q <= 1'b0;
        end else begin
            left_speaker_q <= left_speaker_d;
            right_speaker_q <= right_speaker_d;
            speaker_reserved_q <= speaker_reserved_d;
            dac_delay_q <= dac_delay_d;
            power_on_code_q <= power_on_code_d;
            step_code_q <= step_code_d;
            cm_select_q <= cm_select_d;
        end
    end

    // Status bit follows the detector live; it has meaning only while a driver is up
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            short_seen_q <= 1'b0;
        end else begin
            short_seen_q <= class_d_short;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= reg_read;
        end
    end

    // Headphone driver sequencing
    logic timer_start;
    logic [TW-1:0] timer_load;
    logic timer_done;
    logic [TW-1:0] step_cycles;
    logic [TW-1:0] wait_cycles;
    logic want_on;
    logic level_full;

    assign step_cycles = osc_cycles(sphp_pkg::STEP_TIME_NS[step_code_q]);
    assign wait_cycles = power_on_cycles(power_on_code_q);
    // A pending power-down blocks a new power-up until the DAC request drops
    assign want_on = headphone_amplifier_request && !power_down_q;
    assign level_full = level_q == LEVEL_W'(RAMP_STEPS);

    always_comb begin
        seq_d = seq_q;
        level_d = level_q;
        timer_start = 1'b0;
        timer_load = step_cycles;
        if (!want_on) begin
            seq_d = sphp_pkg::SEQ_OFF;
            level_d = '0;
        end else begin
            unique case (seq_q)
                sphp_pkg::SEQ_OFF: begin
                    seq_d = sphp_pkg::SEQ_WAIT;
                    timer_start = 1'b1;
                    timer_load = wait_cycles;
                end
                sphp_pkg::SEQ_WAIT: begin
                    if (timer_done) begin
                        seq_d = sphp_pkg::SEQ_RAMP;
                        level_d = LEVEL_W'(1);
                        timer_start = 1'b1;
                    end
                end
                sphp_pkg::SEQ_RAMP: begin
                    if (timer_done) begin
                        if (level_full) begin
                            seq_d = sphp_pkg::SEQ_ON;
                        end else begin
                            level_d = level_q + LEVEL_W'(1);
                            timer_start = 1'b1;
                        end
                    end
                end
                sphp_pkg::SEQ_ON: begin
                    seq_d = sphp_pkg::SEQ_ON;
                end
            endcase
        end
    end

    // One timer serves the power-on wait and every ramp step, which never overlap
    sphp_osc_timer #(
        .W(TW)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .osc_tick(osc_tick),
        .start(timer_start),
        .load_value(timer_load),
        .busy(),
        .done(timer_done)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seq_q <= sphp_pkg::SEQ_OFF;
            level_q <= '0;
        end else begin
            seq_q <= seq_d;
            level_q <= level_d;
        end
    end

    // Power-down sequence holds until the DAC request itself is withdrawn
    assign power_down_d = soft_power_down ? 1'b1 : (dac_request ? power_down_q : 1'b0);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_down_q <= 1'b0;
        end else begin
            power_down_q <= power_down_d;
        end
    end

    // Delayed DAC shutdown trades a longer power-down for less pop
    logic dac_cut;
    assign dac_cut = power_down_q && (!dac_delay_q || amplifiers_off);

    // Headphone driver drops in the same cycle as the speakers, not one state later
    logic headphone_powered;
    assign headphone_powered = seq_q != sphp_pkg::SEQ_OFF && !power_down_q;

    // Outputs
    assign left_speaker_output_enable = left_speaker_q && !power_down_q;
    assign right_speaker_output_enable = right_speaker_q && !power_down_q;
    assign headphone_amplifier_enable = headphone_powered;
    assign headphone_amplifier_level = level_q;
    assign headphone_amplifier_ready = headphone_powered && seq_q == sphp_pkg::SEQ_ON;
    assign dac_enable = dac_request && !dac_cut;
    assign common_mode_weak_drive = !cm_select_q;
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

endmodule

// *** verilog/sphp_pkg.sv ***
// Package of offsets, field layouts, reset values and timing for the power sequencer
package sphp_pkg;

    // Register offsets
    localparam logic [7:0] SPEAKER_AMP_OFFSET = 8'h20;
    localparam logic [7:0] HEADPHONE_POP_OFFSET = 8'h21;

    // Speaker amplifier register fields
    localparam int LEFT_SPEAKER_BIT = 7;
    localparam int RIGHT_SPEAKER_BIT = 6;
    localparam int SPK_RSVD_MSB = 5;
    localparam int SPK_RSVD_LSB = 1;
    localparam int SHORT_STATUS_BIT = 0;
    localparam logic [4:0] SPK_RSVD_RESET = 5'h03;

    // Headphone pop-removal register fields
    localparam int DAC_DELAY_BIT = 7;
    localparam int PON_MSB = 6;
    localparam int PON_LSB = 3;
    localparam int STEP_MSB = 2;
    localparam int STEP_LSB = 1;
    localparam int CM_SEL_BIT = 0;
    localparam logic [3:0] PON_RESET = 4'h7;
    localparam logic [1:0] STEP_RESET = 2'h3;
    localparam logic [3:0] PON_LAST_CODE = 4'hb;

    // Nominal internal oscillator, in kHz
    localparam longint OSC_NOMINAL_KHZ = 8200;
    localparam longint NS_PER_MS_KHZ = 1000000;

    // Driver power-on times in ns, one per code 0000 to 1011
    localparam longint PON_TIME_NS [0:11] = '{
        0, 15300, 153000, 1530000, 15300000, 76200000, 153000000,
        304000000, 610000000, 1220000000, 64'd3040000000, 64'd6100000000
    };

    // Driver ramp-up step times in ns, one per code 00 to 11
    localparam longint STEP_TIME_NS [0:3] = '{0, 980000, 1950000, 3900000};

    // Counter wide enough for 6.1 s at the nominal oscillator
    localparam int TIMER_W = 27;

    // Headphone driver sequencing states
    typedef enum logic [1:0] {
        SEQ_OFF = 2'b00,
        SEQ_WAIT = 2'b01,
        SEQ_RAMP = 2'b10,
        SEQ_ON = 2'b11
    } sphp_seq_t;

endpackage

// *** verilog/sphp_osc_timer.sv ***
// Down-counter of internal oscillator ticks for power-on and ramp delays
module sphp_osc_timer #(
    parameter int W = 27
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Oscillator tick, one pulse per oscillator cycle
    input wire logic osc_tick,
    // Control
    input wire logic start,
    input wire logic [W-1:0] load_value,
    // Status
    output logic busy,
    output logic done
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;
    logic reach_zero;

    // A zero load finishes on the next edge without waiting for a tick
    assign reach_zero = busy_q && (count_q == '0 || (osc_tick && count_q == W'(1)));
    assign count_d = start ? load_value :
                     (busy_q && osc_tick && count_q != '0) ? count_q - W'(1) : count_q;
    assign busy_d = start ? 1'b1 : (reach_zero ? 1'b0 : busy_q);
    assign done_d = !start && reach_zero;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;

endmodule

// *** tb/sphp_power_sequencer_asserts.sv ***
// Concurrent checks on the power sequencer ports
module sphp_power_sequencer_asserts #(
    parameter int RAMP_STEPS = 8,
    parameter int LEVEL_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Controls and status
    input wire logic osc_tick,
    input wire logic short_keep_speaker,
    input wire logic soft_power_down,
    input wire logic class_d_short,
    input wire logic amplifiers_off,
    input wire logic headphone_amplifier_request,
    input wire logic dac_request,
    // Outputs
    input wire logic left_speaker_output_enable,
    input wire logic right_speaker_output_enable,
    input wire logic headphone_amplifier_enable,
    input wire logic [LEVEL_W-1:0] headphone_amplifier_level,
    input wire logic headphone_amplifier_ready,
    input wire logic dac_enable,
    input wire logic common_mode_weak_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Shadow of the DAC delay bit, only visible through writes
    logic dac_delay_q;
    wire wr_pop = reg_write && reg_addr == 8'h21;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) dac_delay_q <= 1'b0;
        else if (wr_pop) dac_delay_q <= reg_wdata[7];
    end
    property p_short_clear;
        class_d_short && !short_keep_speaker
            |=> !left_speaker_output_enable && !right_speaker_output_enable;
    endproperty
    a_short_clear: assert property (p_short_clear) else $error("speaker kept on short");
    property p_short_keep;
        class_d_short && short_keep_speaker && !reg_write && !soft_power_down
            && left_speaker_output_enable |=> left_speaker_output_enable;
    endproperty
    a_short_keep: assert property (p_short_keep) else $error("speaker dropped on held short");
    property p_status_bit;
        reg_read && reg_addr == 8'h20 && class_d_short && $past(class_d_short) |=> reg_rdata[0];
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("short status not read");
    property p_rvalid;
        reg_read |=> reg_rvalid ##1 !reg_rvalid || $past(reg_read);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid timing wrong");
    property p_cm_weak;
        wr_pop |=> common_mode_weak_drive == !$past(reg_wdata[0]);
    endproperty
    a_cm_weak: assert property (p_cm_weak) else $error("common mode drive wrong");
    property p_dac_simult;
        soft_power_down && !dac_delay_q && !reg_write |=> !dac_enable;
    endproperty
    a_dac_simult: assert property (p_dac_simult) else $error("DAC not down at once");
    property p_dac_delay;
        soft_power_down && dac_delay_q && !amplifiers_off && !reg_write
            |=> amplifiers_off || dac_enable == dac_request;
    endproperty
    a_dac_delay: assert property (p_dac_delay) else $error("DAC down too early");
    property p_ready_level;
        headphone_amplifier_ready
            |-> headphone_amplifier_level == RAMP_STEPS && headphone_amplifier_enable;
    endproperty
    a_ready_level: assert property (p_ready_level) else $error("ready before full ramp");
    property p_ready_drop;
        !headphone_amplifier_request && headphone_amplifier_ready |=> !headphone_amplifier_ready;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready held after drop");
    property p_pd_speaker;
        soft_power_down |=> !left_speaker_output_enable && !right_speaker_output_enable;
    endproperty
    a_pd_speaker: assert property (p_pd_speaker) else $error("speaker on in power down");
    property p_pd_headphone;
        soft_power_down |=> !headphone_amplifier_enable;
    endproperty
    a_pd_headphone: assert property (p_pd_headphone) else $error("headphone left on");
    c_ready: cover property ($rose(headphone_amplifier_ready));
    c_short: cover property (class_d_short && !short_keep_speaker);
    c_pd: cover property (soft_power_down && dac_delay_q);
endmodule

bind sphp_power_sequencer sphp_power_sequencer_asserts #(
    .RAMP_STEPS(RAMP_STEPS), .LEVEL_W(LEVEL_W)) chk_inst (.*);

// *** tb/test_sphp_power_sequencer.sv ***
// Self-checking bench for the power sequencer
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_sphp_power_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, osc_tick = 0, keep = 0, spd = 0;
    logic short = 0, amp_off = 0, hp_req = 0, dac_req = 0, rvalid, left, right, hp_en, ready;
    logic dac_en, cm_weak;
    logic [7:0] addr = 0, wdata = 0, rdata, rnd;
    logic [3:0] level;
    int seed = 58182, bad_count = 0, cmp_count = 0, cycles = 0, ticks, i;
    int spk_m = 'h06, pop_m = 'h3e;
    always #12.5 clk = ~clk;
    sphp_power_sequencer #(.OSC_KHZ(1), .RAMP_STEPS(2), .LEVEL_W(4)) sphp_power_sequencer_inst (
        .clk(clk), .reset(reset), .reg_addr(addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .osc_tick(osc_tick),
        .short_keep_speaker(keep), .soft_power_down(spd), .class_d_short(short),
        .amplifiers_off(amp_off), .headphone_amplifier_request(hp_req), .dac_request(dac_req),
        .left_speaker_output_enable(left), .right_speaker_output_enable(right),
        .headphone_amplifier_enable(hp_en), .headphone_amplifier_level(level),
        .headphone_amplifier_ready(ready), .dac_enable(dac_en), .common_mode_weak_drive(cm_weak));
    // Oscillator ticks arrive at random, so timing must be counted, not assumed
    always @(posedge clk) begin
        osc_tick <= $random(seed);
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic wait_n(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_write <= 1;
        @(posedge clk);
        reg_write <= 0;
        if (a == 8'h20) spk_m = {d[7:1], spk_m[0]};
        if (a == 8'h21) pop_m = d;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        addr <= a;
        reg_read <= 1;
        @(posedge clk);
        reg_read <= 0;
        #1;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, (a == 8'h20) ? spk_m[7:0] : (a == 8'h21) ? pop_m[7:0] : 8'h00)
    endtask
    task automatic pulse_pd();
        @(posedge clk);
        spd <= 1;
        @(posedge clk);
        spd <= 0;
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        wait_n(12);
        reset <= 0;
        rd(8'h20);
        rd(8'h21);
        `CHK(cm_weak, 1'b1)
        wr(8'h22, 8'hff);
        rd(8'h22);
        rd(8'h21);
        wr(8'h20, 8'h86);
        wait_n(1);
        `CHK({left, right}, 2'b10)
        wr(8'h20, 8'hc6);
        wait_n(1);
        `CHK({left, right}, 2'b11)
        keep <= 1;
        short <= 1;
        wait_n(3);
        `CHK({left, right}, 2'b11)
        spk_m = 'hc7;
        rd(8'h20);
        keep <= 0;
        wait_n(2);
        `CHK({left, right}, 2'b00)
        spk_m = 'h07;
        rd(8'h20);
        short <= 0;
        wait_n(3);
        spk_m = 'h06;
        rd(8'h20);
        // Random timing codes, kept off the reserved power-on codes and common-mode value
        rnd = 8'($random(seed));
        rnd[0] = 1'b0;
        if (rnd[6:3] > 4'hb) rnd[6] = 1'b0;
        wr(8'h21, rnd);
        wait_n(1);
        `CHK(cm_weak, 1'b1)
        rd(8'h21);
        wr(8'h21, 8'h3e);
        // Full power-on wait of code 0111 scaled to a 1 kHz oscillator
        ticks = 0;
        hp_req <= 1;
        for (i = 0; i < 4000 && ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            if (osc_tick) ticks++;
        end
        // 304 ticks of wait, two 3-tick steps, up to four ticks between timer loads
        `CHK(ticks >= 304 + 2 * 3, 1'b1)
        `CHK(ticks <= 304 + 2 * 3 + 4, 1'b1)
        `CHK(level, 4'h2)
        hp_req <= 0;
        wait_n(2);
        `CHK({ready, hp_en}, 2'b00)
        wr(8'h21, 8'h00);
        hp_req <= 1;
        for (i = 0; i < 60 && ready !== 1'b1; i++) wait_n(1);
        `CHK(ready, 1'b1)
        hp_req <= 0;
        dac_req <= 1;
        wr(8'h20, 8'hc6);
        pulse_pd();
        wait_n(1);
        `CHK({dac_en, left}, 2'b00)
        dac_req <= 0;
        wait_n(2);
        dac_req <= 1;
        wr(8'h21, 8'h80);
        wait_n(1);
        `CHK(dac_en, 1'b1)
        pulse_pd();
        wait_n(2);
        `CHK(dac_en, 1'b1)
        amp_off <= 1;
        wait_n(2);
        `CHK(dac_en, 1'b0)
        end_of_test();
    end
endmodule
